// *** rtl/msp_mem_select.sv ***
// Memory select priority, space mapping, sector protection and flash reset control
// Summary of operation
// RULE1 - Program or erase requests to a protected sector are dropped.
// RULE2 - Protection flags readable by host, changed only via test port load.
// RULE3 - Verify reads of protected sectors return the stored flash data.
// RULE4 - Primary protection register: bit n flags sector n protected.
// RULE5 - Secondary register: sector flags bits 3..0, lock in bit 7, 6..4 zero.
// RULE6 - Reset command is one write, optionally after AAh@555h, 55h@AAAh.
// RULE7 - Host issues reset command after status/ID reads or an error.
// RULE8 - After an error, read mode returns within 25 us of reset command.
// RULE9 - Reset command ignored during byte program or bulk erase.
// RULE10 - Reset command aborts sector erase, read mode within 25 us.
// RULE11 - Reset pin aborts any flash cycle, up to 25 us if busy.
// RULE12 - System should hold the reset pin at least 25 us.
// RULE13 - SRAM responds only while its select is high.
// RULE14 - Battery indicator high when enabled and battery powers the SRAM.
// RULE15 - Secondary sector select wins over an overlapping primary select.
// RULE16 - SRAM and I/O selects win over any flash sector select.
// RULE17 - Host decode keeps three levels, no same-level overlap.
// RULE18 - Fetch and read strobes pick spaces per space map register.
// RULE19 - Space map loads from configuration, host may rewrite it.
// RULE20 - Space map bits: 7 PIO, 4/3 read, 2/1/0 fetch enables.
// RULE21 - Separate spaces use space map value 0Ch.
// RULE22 - Combined primary space sets space map bits 2 and 4.
// RULE23 - Error flag set on program timeout or programming an unerased bit.
// RULE24 - Priority and mapping resolved combinationally, one target per cycle.
`timescale 1ns/1ps
module msp_mem_select
  import msp_pkg::*;
#(
  parameter int PRI_SECTORS = 8,
  parameter int SEC_SECTORS = 4
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   ce_i,
  input  wire logic [15:0]            bus_addr_i,
  input  wire logic [7:0]             bus_wdata_i,
  input  wire logic                   bus_wr_i,
  input  wire logic                   control_input_one_i,
  input  wire logic                   program_fetch_strobe_i,
  output logic [7:0]                  bus_rdata_o,
  input  wire logic [PRI_SECTORS-1:0] primary_sector_selects_i,
  input  wire logic [SEC_SECTORS-1:0] secondary_sector_selects_i,
  input  wire logic                   sram_select_i,
  input  wire logic                   io_select_i,
  input  wire logic [1:0]             periph_io_select_i,
  input  wire logic                   config_register_space_i,
  input  wire logic [7:0]             space_map_init_i,
  input  wire logic                   prot_load_i,
  input  wire logic [PRI_SECTORS-1:0] prot_primary_i,
  input  wire logic [SEC_SECTORS-1:0] prot_secondary_i,
  input  wire logic                   security_lock_i,
  input  wire logic                   flash_prog_req_i,
  input  wire logic                   flash_erase_req_i,
  input  wire logic [7:0]             flash_rdata_i,
  input  wire logic                   byte_prog_busy_i,
  input  wire logic                   bulk_erase_busy_i,
  input  wire logic                   sector_erase_busy_i,
  input  wire logic                   prog_timeout_i,
  input  wire logic                   prog_unerased_i,
  input  wire logic                   reset_pin_n_i,
  input  wire logic                   battery_ind_cfg_i,
  input  wire logic                   standby_supply_input_i,
  output logic [PRI_SECTORS-1:0]      primary_en_o,
  output logic [SEC_SECTORS-1:0]      secondary_en_o,
  output logic                        sram_en_o,
  output logic                        io_en_o,
  output logic [1:0]                  periph_io_en_o,
  output logic                        flash_prog_go_o,
  output logic                        flash_erase_go_o,
  output logic                        flash_abort_o,
  output logic                        flash_read_mode_o,
  output logic                        error_flag_bit_o,
  output logic                        battery_on_indicator_o
);

  typedef struct packed {
    logic [1:0]             rst_sync;
    logic                   rst_prev;
    logic [1:0]             bat_sync;
    logic                   bat_on;
    msp_cmd_e               cmd;
    logic [7:0]             space_map;
    logic [PRI_SECTORS-1:0] pri_prot;
    logic [SEC_SECTORS-1:0] sec_prot;
    logic                   lock;
    logic                   err;
    logic                   abort;
    logic [7:0]             rdata;
  } msp_state_s;

  msp_state_s st_r;
  msp_state_s st_nxt;

  // Lowest-numbered active select wins; guards against host decode overlap
  function automatic logic [7:0] first_one(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'h00;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  logic                   rd_cyc;
  logic                   fetch_cyc;
  logic                   level1;
  logic                   sec_hit;
  logic                   pri_ok;
  logic                   sec_ok;
  logic                   sram_ok;
  logic [7:0]             pri_one;
  logic [7:0]             sec_one;
  logic [7:0]             pio_one;
  logic                   prot_hit;
  logic                   flash_wr;
  logic                   cfg_rd;
  logic                   cfg_wr;
  logic                   rst_cmd;
  logic                   rst_take;
  logic                   rst_wait;
  logic                   pin_active;
  logic                   op_active;
  logic                   tmr_start;
  logic                   tmr_busy;
  logic                   tmr_done;

  assign rd_cyc    = control_input_one_i;
  assign fetch_cyc = program_fetch_strobe_i;

  // Space gating per strobe
  assign pri_ok  = bus_wr_i | (rd_cyc & st_r.space_map[VM_PRI_DATA])
                 | (fetch_cyc & st_r.space_map[VM_PRI_CODE]); // RULE18
  assign sec_ok  = bus_wr_i | (rd_cyc & st_r.space_map[VM_SEC_DATA])
                 | (fetch_cyc & st_r.space_map[VM_SEC_CODE]); // RULE18
  assign sram_ok = bus_wr_i | rd_cyc | (fetch_cyc & st_r.space_map[VM_SRAM_CODE]); // RULE20

  // Level one targets block every flash select
  assign pio_one = first_one({6'h00, periph_io_select_i});
  assign level1  = sram_select_i | io_select_i
                 | (st_r.space_map[VM_PERIPHERAL_IO_MODE_ENABLE] & (|periph_io_select_i)); // RULE16
  assign sec_hit = ~level1 & (|secondary_sector_selects_i); // RULE15
  assign pri_one = first_one(8'(primary_sector_selects_i));
  assign sec_one = first_one(8'(secondary_sector_selects_i));

  always_comb begin
    sram_en_o      = sram_select_i & sram_ok; // RULE13
    io_en_o        = ~sram_select_i & io_select_i & (bus_wr_i | rd_cyc);
    periph_io_en_o = '0;
    if (~sram_select_i & ~io_select_i & st_r.space_map[VM_PERIPHERAL_IO_MODE_ENABLE]) begin
      periph_io_en_o = pio_one[1:0];
    end
    secondary_en_o = '0;
    primary_en_o   = '0;
    if (sec_hit & sec_ok) begin
      secondary_en_o = sec_one[SEC_SECTORS-1:0]; // RULE15
    end else if (~level1 & ~sec_hit & pri_ok) begin
      primary_en_o = pri_one[PRI_SECTORS-1:0]; // RULE24
    end
  end

  // Protection gate on the addressed sector only
  assign prot_hit = (|(primary_en_o & st_r.pri_prot))
                  | (|(secondary_en_o & st_r.sec_prot));
  assign flash_prog_go_o  = flash_prog_req_i & ~prot_hit
                          & (|{primary_en_o, secondary_en_o}); // RULE1
  assign flash_erase_go_o = flash_erase_req_i & ~prot_hit
                          & (|{primary_en_o, secondary_en_o}); // RULE1

  // Host accesses
  assign flash_wr = bus_wr_i & (|{primary_en_o, secondary_en_o});
  assign cfg_rd   = rd_cyc & config_register_space_i;
  assign cfg_wr   = bus_wr_i & config_register_space_i;

  // Reset command and reset pin handling
  assign rst_cmd    = flash_wr & (bus_wdata_i == RESET_CMD_DATA); // RULE6
  assign rst_take   = rst_cmd & ~byte_prog_busy_i & ~bulk_erase_busy_i; // RULE9
  assign rst_wait   = rst_take & (sector_erase_busy_i | st_r.err); // RULE10
  assign pin_active = ~st_r.rst_sync[1];
  assign op_active  = byte_prog_busy_i | bulk_erase_busy_i | sector_erase_busy_i;
  assign tmr_start  = rst_wait | (pin_active & ~st_r.rst_prev & op_active); // RULE11

  msp_recover_timer #(
    .CYCLES (RECOVER_CYCLES)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .start_i   (tmr_start),
    .busy_o    (tmr_busy),
    .done_o    (tmr_done)
  );

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], reset_pin_n_i};
    st_nxt.rst_prev = pin_active;
    st_nxt.bat_sync = {st_r.bat_sync[0], standby_supply_input_i};
    st_nxt.bat_on   = battery_ind_cfg_i & st_r.bat_sync[1]; // RULE14
    st_nxt.abort    = rst_take | pin_active; // RULE11

    // Command sequencer; other command codes belong to the flash engine
    case (st_r.cmd)
      CMD_IDLE: begin
        if (flash_wr & (bus_addr_i == UNLOCK1_ADDR) & (bus_wdata_i == UNLOCK1_DATA)) begin
          st_nxt.cmd = CMD_UNL1; // RULE6
        end
      end
      CMD_UNL1: begin
        if (flash_wr & (bus_addr_i == UNLOCK2_ADDR) & (bus_wdata_i == UNLOCK2_DATA)) begin
          st_nxt.cmd = CMD_UNL2; // RULE6
        end else if (flash_wr) begin
          st_nxt.cmd = CMD_IDLE;
        end
      end
      CMD_UNL2: begin
        if (flash_wr) begin
          st_nxt.cmd = CMD_IDLE;
        end
      end
      default: begin
        st_nxt.cmd = CMD_IDLE;
      end
    endcase
    if (pin_active) begin
      st_nxt.cmd = CMD_IDLE;
    end

    // Error flag: a new error beats a same-cycle clear
    if ((rst_take & ~rst_wait) | tmr_done) begin
      st_nxt.err = 1'b0;
    end
    if (prog_timeout_i | prog_unerased_i) begin
      st_nxt.err = 1'b1; // RULE23
    end

    // Protection flags move only from the test port
    if (prot_load_i) begin
      st_nxt.pri_prot = prot_primary_i; // RULE2
      st_nxt.sec_prot = prot_secondary_i;
      st_nxt.lock     = security_lock_i;
    end

    if (cfg_wr & (bus_addr_i[7:0] == REG_SPACE_MAP)) begin
      st_nxt.space_map = bus_wdata_i; // RULE19
    end

    // Read data; flash data passes unmasked so verify sees stored bytes
    if (cfg_rd) begin
      case (bus_addr_i[7:0])
        REG_PRI_PROT:  st_nxt.rdata = 8'(st_r.pri_prot); // RULE4
        REG_SEC_PROT:  st_nxt.rdata = {st_r.lock, SEC_UNUSED_VAL,
                                       4'(st_r.sec_prot)}; // RULE5
        REG_SPACE_MAP: st_nxt.rdata = st_r.space_map;
        default:       st_nxt.rdata = 8'h00;
      endcase
    end else if ((rd_cyc | fetch_cyc) & (|{primary_en_o, secondary_en_o})) begin
      st_nxt.rdata = flash_rdata_i; // RULE3
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r.rst_sync  <= SYNC_RESET_HIGH;
      st_r.rst_prev  <= 1'b0;
      st_r.bat_sync  <= SYNC_RESET_LOW;
      st_r.bat_on    <= 1'b0;
      st_r.cmd       <= CMD_IDLE;
      st_r.space_map <= space_map_init_i; // RULE19
      st_r.pri_prot  <= prot_primary_i;
      st_r.sec_prot  <= prot_secondary_i;
      st_r.lock      <= security_lock_i;
      st_r.err       <= 1'b0;
      st_r.abort     <= 1'b0;
      st_r.rdata     <= RDATA_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata_o            = st_r.rdata;
  assign flash_abort_o          = st_r.abort;
  assign flash_read_mode_o      = ~tmr_busy & ~pin_active;
  assign error_flag_bit_o       = st_r.err;
  assign battery_on_indicator_o = st_r.bat_on;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_one_target : assert property (
    $onehot0({primary_en_o, secondary_en_o, sram_en_o, io_en_o, periph_io_en_o})) // RULE24
    else $error("more than one target enabled");
  a_prot_drop : assert property (
    prot_hit |-> !flash_prog_go_o && !flash_erase_go_o) // RULE1
    else $error("request passed to protected sector");
  a_prot_hold : assert property (
    ce_i && !prot_load_i |=> st_r.pri_prot == $past(st_r.pri_prot)
      && st_r.sec_prot == $past(st_r.sec_prot)) // RULE2
    else $error("protection changed without test port");
  a_pri_status : assert property (
    ce_i && cfg_rd && bus_addr_i[7:0] == REG_PRI_PROT
      |=> bus_rdata_o == 8'($past(st_r.pri_prot))) // RULE4
    else $error("primary protection read wrong");
  a_sec_status : assert property (
    ce_i && cfg_rd && bus_addr_i[7:0] == REG_SEC_PROT
      |=> bus_rdata_o[7] == $past(st_r.lock) && bus_rdata_o[6:4] == 3'h0) // RULE5
    else $error("secondary protection read wrong");
  a_verify_data : assert property (
    ce_i && !cfg_rd && rd_cyc && (|primary_en_o)
      |=> bus_rdata_o == $past(flash_rdata_i)) // RULE3
    else $error("verify read did not return flash data");
  a_sec_wins : assert property (
    sec_hit |-> primary_en_o == '0) // RULE15
    else $error("primary enabled over secondary");
  a_level1_wins : assert property (
    level1 |-> primary_en_o == '0 && secondary_en_o == '0) // RULE16
    else $error("flash enabled over level one target");
  a_busy_ignore : assert property (
    ce_i && rst_cmd && (byte_prog_busy_i || bulk_erase_busy_i) && reset_pin_n_i
      && st_r.rst_sync == 2'h3 |=> !flash_abort_o) // RULE9
    else $error("reset command aborted program or bulk erase");
  a_map_write : assert property (
    ce_i && cfg_wr && bus_addr_i[7:0] == REG_SPACE_MAP
      |=> st_r.space_map == $past(bus_wdata_i)) // RULE19
    else $error("space map not updated");
  a_error_set : assert property (
    ce_i && (prog_timeout_i || prog_unerased_i) |=> error_flag_bit_o) // RULE23
    else $error("error flag not set");
  a_batt_ind : assert property (
    ce_i ##1 ce_i |-> battery_on_indicator_o
      == ($past(battery_ind_cfg_i) && $past(st_r.bat_sync[1]))) // RULE14
    else $error("battery indicator wrong");
  a_pin_abort : assert property (
    ce_i && pin_active |-> !flash_read_mode_o ##1 flash_abort_o) // RULE11
    else $error("reset pin did not abort");

endmodule

// *** rtl/msp_pkg.sv ***
// Constants and types shared by the memory select and protection block
package msp_pkg;

  // Register offsets inside the configuration register space (low address byte)
  localparam logic [7:0] REG_PRI_PROT  = 8'hC0;
  localparam logic [7:0] REG_SEC_PROT  = 8'hC2;
  localparam logic [7:0] REG_SPACE_MAP = 8'hE2;

  // Space map field positions
  localparam int VM_PERIPHERAL_IO_MODE_ENABLE    = 7;
  localparam int VM_PRI_DATA  = 4;
  localparam int VM_SEC_DATA  = 3;
  localparam int VM_PRI_CODE  = 2;
  localparam int VM_SEC_CODE  = 1;
  localparam int VM_SRAM_CODE = 0;

  // Secondary protection register layout
  localparam int SEC_LOCK_BIT = 7;
  localparam logic [2:0] SEC_UNUSED_VAL = 3'h0;

  // Flash command cycles
  localparam logic [15:0] UNLOCK1_ADDR   = 16'h0555;
  localparam logic [7:0]  UNLOCK1_DATA   = 8'hAA;
  localparam logic [15:0] UNLOCK2_ADDR   = 16'h0AAA;
  localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
  localparam logic [7:0]  RESET_CMD_DATA = 8'hF0;

  // Return-to-read-mode time; longest time, so cycles round down
  localparam int CLK_PERIOD_NS   = 40;
  localparam int RECOVER_TIME_NS = 25000;
  localparam int RECOVER_CYCLES  = RECOVER_TIME_NS / CLK_PERIOD_NS;

  // Values after reset
  localparam logic [1:0] SYNC_RESET_HIGH = 2'h3;
  localparam logic [1:0] SYNC_RESET_LOW  = 2'h0;
  localparam logic [7:0] RDATA_RESET     = 8'h00;

  typedef enum logic [2:0] {
    CMD_IDLE = 3'h1,
    CMD_UNL1 = 3'h2,
    CMD_UNL2 = 3'h4
  } msp_cmd_e;

endpackage

// *** rtl/msp_recover_timer.sv ***
// Counts the flash return-to-read-mode interval after an abort
`timescale 1ns/1ps
module msp_recover_timer
  import msp_pkg::*;
#(
  parameter int CYCLES = RECOVER_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
  } msp_tmr_s;

  msp_tmr_s st_r;
  msp_tmr_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (start_i) begin
      // A fresh abort restarts the full interval
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = LAST;
    end else if (st_r.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign done_o = st_r.done;

  a_tmr_load : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && start_i |=> busy_o && st_r.cnt == LAST) // RULE8
    else $error("timer did not load full interval");
  a_tmr_finish : assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && !start_i && busy_o && st_r.cnt == '0 |=> !busy_o && done_o) // RULE10
    else $error("timer did not end at zero");

endmodule

// *** bench/msp_host_model.sv ***
// Host-side select decoder and flash array data model
`timescale 1ns/1ps
module msp_host_model (
  input  wire logic [15:0] addr_i,
  output logic [7:0]       pri_sel_o,
  output logic [3:0]       sec_sel_o,
  output logic             sram_sel_o,
  output logic             io_sel_o,
  output logic [1:0]       pio_sel_o,
  output logic             cfg_sel_o,
  output logic [7:0]       flash_data_o
);
  logic pg_ff;
  always_comb begin
    pg_ff        = addr_i[15:8] == 8'hFF;
    cfg_sel_o    = pg_ff;
    io_sel_o     = addr_i[15:8] == 8'hFE;
    pio_sel_o    = {addr_i[15:8] == 8'hFC, addr_i[15:8] == 8'hFD};
    sram_sel_o   = addr_i[15:11] == 5'h12;
    // Flash levels kept off the config page; same-level selects never overlap
    pri_sel_o    = pg_ff ? 8'h00 : 8'h01 << addr_i[15:13];
    sec_sel_o    = (addr_i[15:12] == 4'h8) ? 4'h1 << addr_i[11:10] : 4'h0;
    flash_data_o = addr_i[7:0] ^ addr_i[15:8] ^ 8'h5A;
  end
endmodule

// *** bench/memory_select_and_protect_test.sv ***
// Self-checking bench for the memory select and protection block
`timescale 1ns/1ps
module memory_select_and_protect_test;
  import msp_pkg::*;
  logic        sys_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
  logic [15:0] bus_addr_i = 16'h0000;
  logic [7:0]  bus_wdata_i = 8'h00, map_init = 8'h1F, pri_prot = 8'hA5, map_m = 8'h1F;
  logic [3:0]  sec_prot = 4'h9;
  logic        wr = 1'b0, rd = 1'b0, fe = 1'b0, ld = 1'b0, lock = 1'b1, preq = 1'b0;
  logic        ereq = 1'b0, bp = 1'b0, be = 1'b0, se = 1'b0, tmo = 1'b0, une = 1'b0;
  logic        pin_n = 1'b1, bcfg = 1'b0, stby = 1'b0;
  logic [7:0]  rdata, pri_sel, pri_en, fdata;
  logic [3:0]  sec_sel, sec_en;
  logic [1:0]  pio_sel, peripheral_io_mode_enable;
  logic        sram_sel, io_sel, cfg_sel, sram_en, io_en, pgo, ego, abort, rmode, err, bat;
  int          fails = 0, cmp_count = 0;
  logic [31:0] seed = 32'h94A8;

  always #20 sys_clk_i = ~sys_clk_i;

  msp_host_model msp_host_model_i (
    .addr_i(bus_addr_i), .pri_sel_o(pri_sel), .sec_sel_o(sec_sel), .sram_sel_o(sram_sel),
    .io_sel_o(io_sel), .pio_sel_o(pio_sel), .cfg_sel_o(cfg_sel), .flash_data_o(fdata)
  );

  msp_mem_select msp_mem_select_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(wr), .control_input_one_i(rd),
    .program_fetch_strobe_i(fe), .bus_rdata_o(rdata), .primary_sector_selects_i(pri_sel),
    .secondary_sector_selects_i(sec_sel), .sram_select_i(sram_sel), .io_select_i(io_sel),
    .periph_io_select_i(pio_sel), .config_register_space_i(cfg_sel),
    .space_map_init_i(map_init), .prot_load_i(ld), .prot_primary_i(pri_prot),
    .prot_secondary_i(sec_prot), .security_lock_i(lock), .flash_prog_req_i(preq),
    .flash_erase_req_i(ereq), .flash_rdata_i(fdata), .byte_prog_busy_i(bp),
    .bulk_erase_busy_i(be), .sector_erase_busy_i(se), .prog_timeout_i(tmo),
    .prog_unerased_i(une), .reset_pin_n_i(pin_n), .battery_ind_cfg_i(bcfg),
    .standby_supply_input_i(stby), .primary_en_o(pri_en), .secondary_en_o(sec_en),
    .sram_en_o(sram_en), .io_en_o(io_en), .periph_io_en_o(peripheral_io_mode_enable), .flash_prog_go_o(pgo),
    .flash_erase_go_o(ego), .flash_abort_o(abort), .flash_read_mode_o(rmode),
    .error_flag_bit_o(err), .battery_on_indicator_o(bat)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {primary, secondary, sram, io, pio} enables
  function automatic logic [15:0] exp_en(input int k, input logic [7:0] m);
    logic [15:0] e;
    logic        f;
    e = 16'h0000;
    f = k == 2;
    if (sram_sel) e[3] = !f || m[0];
    else if (io_sel) e[2] = !f;
    // Peripheral selects are not gated by any strobe
    else if (m[7] && pio_sel != 2'b00) e[1:0] = pio_sel[0] ? 2'b01 : 2'b10;
    else if (sec_sel != 4'h0) e[7:4] = (k == 0 || k == 1 && m[3] || f && m[1]) ? sec_sel : 4'h0;
    else e[15:8] = (k == 0 || k == 1 && m[4] || f && m[2]) ? pri_sel : 8'h00;
    return e;
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] x, input string what);
    cmp_count++;
    if (got !== x) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, x);
    end
  endtask

  // Strobes stay high into the next call, so calls in a row are back-to-back
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input int k,
                     input logic [1:0] rq = 2'b00);
    @(posedge sys_clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    wr <= k == 0;
    rd <= k == 1;
    fe <= k == 2;
    {preq, ereq} <= rq;
    #1;
    chk({pri_en, sec_en, sram_en, io_en, peripheral_io_mode_enable}, exp_en(k, map_m), "enables");
    if (k == 0 && a == 16'hFFE2) map_m = d;
  endtask

  task automatic idle();
    @(posedge sys_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    fe <= 1'b0;
    {preq, ereq} <= 2'b00;
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
    bus(a, 8'h00, 1);
    idle();
    chk(rdata, x, "read data");
  endtask

  task automatic cmd(input bit unl, input logic x);
    if (unl) begin
      bus(UNLOCK1_ADDR, UNLOCK1_DATA, 0);
      bus(UNLOCK2_ADDR, UNLOCK2_DATA, 0);
    end
    bus(16'h0000, RESET_CMD_DATA, 0);
    idle();
    chk(abort, x, "abort pulse");
  endtask

  task automatic wait_rm(output int n);
    n = 0;
    while (rmode !== 1'b1 && n < 700) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 700) begin
      fails++;
      $display("MISMATCH t=%0t read mode never returned", $time);
      print_verdict();
    end
  endtask

  initial begin
    int          n;
    logic [15:0] a;
    logic [31:0] r;
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd_chk(16'hFFC0, 8'hA5);
    rd_chk(16'hFFC2, {lock, 3'h0, sec_prot});
    rd_chk(16'hFFE2, map_init);
    bus(16'hFFC0, 8'h00, 0);
    bus(16'hFFC2, 8'h00, 0);
    idle();
    rd_chk(16'hFFC0, 8'hA5);
    rd_chk(16'hFFC2, {lock, 3'h0, sec_prot});
    $display("test register reset and write refusal done");
    bus(16'hFFE2, 8'h18, 0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      @(posedge sys_clk_i);
      ld <= 1'b1;
      pri_prot <= r[7:0];
      sec_prot <= r[11:8];
      lock <= r[12];
      @(posedge sys_clk_i);
      ld <= 1'b0;
      rd_chk(16'hFFC0, pri_prot);
      rd_chk(16'hFFC2, {lock, 3'h0, sec_prot});
      for (int s = 0; s < 12; s++) begin
        a = (s < 8) ? {s[2:0], 13'h1900} : {4'h8, s[1:0], 10'h055};
        for (int q = 1; q < 3; q++) begin
          bus(a, 8'h00, 0, q[1:0]);
          chk({pgo, ego}, q[1:0] & {2{!((s < 8) ? pri_prot[s] : sec_prot[s - 8])}}, "go");
        end
        rd_chk(a, a[7:0] ^ a[15:8] ^ 8'h5A);
      end
    end
    cmd(1'b0, 1'b1);
    $display("test protection done");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      if (i == 0) r[7:0] = 8'h0C;
      if (i == 1) r[7:0] = 8'h14;
      bus(16'hFFE2, r[7:0] & 8'h9F, 0);
      idle();
      rd_chk(16'hFFE2, r[7:0] & 8'h9F);
      for (int j = 0; j < 20; j++) begin
        r = rnd();
        a = r[15:0];
        bus(a, r[23:16], (a[15:8] == 8'hFF) ? 1 : int'(r[31:24] % 3));
      end
      idle();
    end
    $display("test select priority and space map done");
    for (int u = 0; u < 2; u++) begin
      cmd(u[0], 1'b1);
      chk(rmode, 1'b1, "read mode");
      idle();
      chk(abort, 1'b0, "abort one cycle");
    end
    for (int b = 0; b < 2; b++) begin
      @(posedge sys_clk_i);
      bp <= b == 0;
      be <= b == 1;
      cmd(1'b1, 1'b0);
    end
    @(posedge sys_clk_i);
    bp <= 1'b0;
    be <= 1'b0;
    se <= 1'b1;
    cmd(1'b1, 1'b1);
    chk(rmode, 1'b0, "read mode after abort");
    @(posedge sys_clk_i);
    se <= 1'b0;
    wait_rm(n);
    chk(n <= RECOVER_CYCLES, 1'b1, "sector erase recovery");
    for (int c = 0; c < 2; c++) begin
      @(posedge sys_clk_i);
      tmo <= c == 0;
      une <= c == 1;
      @(posedge sys_clk_i);
      tmo <= 1'b0;
      une <= 1'b0;
      #1;
      chk(err, 1'b1, "error set");
      cmd(c[0], 1'b1);
      wait_rm(n);
      // Error clears on the edge after the timer's done pulse
      idle();
      chk(n <= RECOVER_CYCLES && err === 1'b0, 1'b1, "error recovery");
    end
    $display("test reset command done");
    @(posedge sys_clk_i);
    se <= 1'b1;
    pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk({abort, rmode}, 2'b10, "pin abort");
    // Pin held well past the recovery time, as the system should
    repeat (650) @(posedge sys_clk_i);
    pin_n <= 1'b1;
    se <= 1'b0;
    wait_rm(n);
    // Registered abort trails the synchronised pin by one edge
    idle();
    chk(abort, 1'b0, "pin released");
    $display("test reset pin done");
    for (int v = 0; v < 3; v++) begin
      @(posedge sys_clk_i);
      bcfg <= v != 2;
      stby <= v != 1;
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk(bat, v == 0, "battery indicator");
    end
    $display("test battery indicator done");
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    map_m = map_init;
    rd_chk(16'hFFE2, map_init);
    $display("test second reset done");
    print_verdict();
  end
endmodule
